// [core/chan_ops_unit.sv]
/*
  Execution unit for the carry add, decimal add, decrement, clear, block
  rewind, drop-last-character and block check channel operations.
  Assumes the sequencer presents one instruction per issue pulse, that the
  line control table is reachable through one combinational read port and
  one write strobe, and that the current control block fields are held here.
*/
module chan_ops_unit
  import chan_ops_pkg::*;
#(
  parameter logic [15:0] CRC_POLY_P = CRC_POLY
) (
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic resetn,
  // Instruction issue.
  input wire logic issue,
  input wire instr_t instr,
  // Line control table port; read data answers rd_index in the same cycle.
  output logic [7:0] table_rd_index,
  input wire logic [7:0] table_rd_data,
  output logic table_wr,
  output logic [7:0] table_wr_index,
  output logic [7:0] table_wr_data,
  // Control block loading and store-pointer advance.
  input wire logic block_load,
  input wire logic [15:0] block_init_addr,
  input wire logic [15:0] block_init_range,
  input wire logic store_done,
  // Architectural state seen by the rest of the channel.
  output logic [7:0] r_reg,
  output logic [7:0] b_reg,
  output flags_t flags,
  output logic [15:0] cur_addr,
  output logic [15:0] cur_range,
  output logic [15:0] crc_residue,
  output logic decoded
);

  // ----------------------------------------------------------------------
  // Arithmetic helpers
  // ----------------------------------------------------------------------

  // Binary add with carry in; bit 8 is the carry out of bit seven.
  function automatic logic [8:0] add_c(input logic [7:0] a,
                                       input logic [7:0] b,
                                       input logic ci);
    add_c = {1'b0, a} + {1'b0, b} + {8'h00, ci};
  endfunction

  // Packed decimal add. Each digit is binary-added and corrected by six
  // when above nine; invalid nibbles simply run through the same path,
  // so the result is defined without any check.
  function automatic logic [8:0] bcd_add(input logic [7:0] a,
                                         input logic [7:0] b);
    logic [4:0] lo;
    logic [4:0] hi;
    logic c_lo;
    logic c_hi;
    lo = {1'b0, a[3:0]} + {1'b0, b[3:0]};
    c_lo = (lo > 5'd9);
    if (c_lo) begin
      lo = lo + 5'd6;
    end
    hi = {1'b0, a[7:4]} + {1'b0, b[7:4]} + {4'h0, c_lo};
    // The carry is taken from the compare, not from bit four, because a
    // corrected sum of two bad digits can wrap past five bits.
    c_hi = (hi > 5'd9);
    if (c_hi) begin
      hi = hi + 5'd6;
    end
    bcd_add = {c_hi, hi[3:0], lo[3:0]};
  endfunction

  // Indicators from a 9-bit result holding carry in bit 8.
  function automatic flags_t flags_of(input logic [8:0] res);
    flags_of.carry = res[8];
    flags_of.sign_indicator = res[7];
    flags_of.zero = (res[7:0] == 8'h00);
  endfunction

  // One byte folded into the residue, low bit first.
  function automatic logic [15:0] crc_fold(input logic [15:0] crc,
                                           input logic [7:0] data);
    logic [15:0] c;
    c = crc ^ {8'h00, data};
    for (int i = 0; i < 8; i++) begin
      c = c[0] ? ((c >> 1) ^ CRC_POLY_P) : (c >> 1);
    end
    crc_fold = c;
  endfunction

  // ----------------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------------
  logic [8:0] alu;
  logic alu_valid;
  logic [15:0] init_addr;
  logic [15:0] init_range;
  logic drop_active;
  logic [15:0] range_gap;

  // Indexed forms address the table through B, direct ones through byte two.
  always_comb begin
    table_rd_index = instr.operand;
    if (instr.opcode == OP_CARRY_ADD_R_INDEXED) begin
      table_rd_index = b_reg;
    end
  end

  // Result and indicator source for all flag-updating operations except drop.
  always_comb begin
    alu = 9'h000;
    alu_valid = 1'b1;
    decoded = 1'b1;
    unique case (instr.opcode)
      OP_CARRY_ADD: alu = add_c(r_reg, table_rd_data, flags.carry);
      OP_CARRY_ADD_B_TABLE: begin
        alu = add_c(b_reg, table_rd_data, flags.carry);
      end
      OP_CARRY_ADD_R_INDEXED: begin
        alu = add_c(r_reg, table_rd_data, flags.carry);
      end
      OP_CARRY_ADD_R_IMMEDIATE: begin
        alu = add_c(r_reg, instr.operand, flags.carry);
      end
      OP_CARRY_ADD_B_IMMEDIATE: begin
        alu = add_c(b_reg, instr.operand, flags.carry);
      end
      OP_BCD_ADD_TABLE: alu = bcd_add(r_reg, table_rd_data);
      OP_BCD_ADD_IMMEDIATE: alu = bcd_add(r_reg, instr.operand);
      // Borrow is reported as carry set when R was zero.
      OP_SUBTRACT_ONE: alu = {1'b0, r_reg} - 9'h001;
      OP_REWIND_BLOCK, OP_DROP_LAST_CHAR, OP_CRC_UPDATE,
      OP_ZERO_TABLE_ENTRY, OP_ZERO_INDEXED_ENTRY,
      OP_ZERO_R, OP_ZERO_B: alu_valid = 1'b0;
      default: begin
        alu_valid = 1'b0;
        decoded = 1'b0;
      end
    endcase
  end

  // Drop is skipped when nothing has been consumed from the block.
  assign range_gap = init_range - cur_range;
  assign drop_active = issue && (instr.opcode == OP_DROP_LAST_CHAR) &&
                       (range_gap != 16'h0000);

  // ----------------------------------------------------------------------
  // Line control table writes
  // ----------------------------------------------------------------------

  // Clears go out as a single-cycle write strobe with zero data.
  always_comb begin
    table_wr = 1'b0;
    table_wr_index = instr.operand;
    table_wr_data = 8'h00;
    if (issue && instr.opcode == OP_ZERO_TABLE_ENTRY) begin
      table_wr = 1'b1;
    end
    if (issue && instr.opcode == OP_ZERO_INDEXED_ENTRY) begin
      table_wr = 1'b1;
      table_wr_index = b_reg;
    end
  end

  // ----------------------------------------------------------------------
  // R and B registers
  // ----------------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      r_reg <= REG_RESET;
    end else if (issue) begin
      unique case (instr.opcode)
        OP_CARRY_ADD, OP_CARRY_ADD_R_INDEXED, OP_CARRY_ADD_R_IMMEDIATE,
        OP_BCD_ADD_TABLE, OP_BCD_ADD_IMMEDIATE, OP_SUBTRACT_ONE: begin
          r_reg <= alu[7:0];
        end
        OP_ZERO_R: r_reg <= REG_RESET;
        default: r_reg <= r_reg;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      b_reg <= REG_RESET;
    end else if (issue) begin
      unique case (instr.opcode)
        OP_CARRY_ADD_B_TABLE, OP_CARRY_ADD_B_IMMEDIATE: begin
          b_reg <= alu[7:0];
        end
        OP_ZERO_B: b_reg <= REG_RESET;
        default: b_reg <= b_reg;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Indicators
  // ----------------------------------------------------------------------

  // Rewind, block check and clears leave the indicators alone; the drop
  // operation only touches Z, and even a skipped drop reports it.
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      flags <= FLAGS_RESET;
    end else if (issue && alu_valid) begin
      flags <= flags_of(alu);
    end else if (issue && instr.opcode == OP_DROP_LAST_CHAR) begin
      flags.zero <= (range_gap == 16'h0000);
    end
  end

  // ----------------------------------------------------------------------
  // Current control block
  // ----------------------------------------------------------------------

  // Initial values are captured when firmware loads a fresh block.
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      init_addr <= 16'h0000;
      init_range <= 16'h0000;
    end else if (block_load) begin
      init_addr <= block_init_addr;
      init_range <= block_init_range;
    end
  end

  // A store advances the pointer and consumes range; a drop backs both off
  // by one, so the following store overwrites the dropped character.
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      cur_addr <= 16'h0000;
      cur_range <= 16'h0000;
    end else if (block_load) begin
      cur_addr <= block_init_addr;
      cur_range <= block_init_range;
    end else if (issue && instr.opcode == OP_REWIND_BLOCK) begin
      cur_addr <= init_addr;
      cur_range <= init_range;
    end else if (drop_active) begin
      cur_range <= cur_range + 16'h0001;
      cur_addr <= cur_addr - 16'h0001;
    end else if (store_done) begin
      cur_addr <= cur_addr + 16'h0001;
      cur_range <= cur_range - 16'h0001;
    end
  end

  // ----------------------------------------------------------------------
  // Block check residue
  // ----------------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      crc_residue <= CRC_RESET;
    end else if (issue && instr.opcode == OP_CRC_UPDATE) begin
      crc_residue <= crc_fold(crc_residue, r_reg);
    end
  end

endmodule // chan_ops_unit

// [include/chan_ops_pkg.sv]
/*
  Shared constants and types for the channel program arithmetic and clear
  operation unit: opcode byte values, widths, reset values and the packed
  structs that carry an instruction and the indicator set.
  Assumes a single synchronous clock domain and 8-bit channel registers.
*/
package chan_ops_pkg;

  // ----------------------------------------------------------------------
  // Widths and reset values
  // ----------------------------------------------------------------------
  localparam int DATA_W = 8;
  localparam int ADDR_W = 16;
  localparam int CRC_W = 16;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [15:0] CRC_RESET = 16'h0000;
  // Reflected CRC-16 polynomial; a parameter default, not a fixed choice.
  localparam logic [15:0] CRC_POLY = 16'hA001;

  // ----------------------------------------------------------------------
  // Opcode bytes (first instruction byte)
  // ----------------------------------------------------------------------
  localparam logic [7:0] OP_CARRY_ADD = 8'h57;
  localparam logic [7:0] OP_CARRY_ADD_B_TABLE = 8'h7D;
  localparam logic [7:0] OP_CARRY_ADD_R_INDEXED = 8'h8C;
  localparam logic [7:0] OP_CARRY_ADD_R_IMMEDIATE = 8'h96;
  localparam logic [7:0] OP_CARRY_ADD_B_IMMEDIATE = 8'hBA;
  localparam logic [7:0] OP_REWIND_BLOCK = 8'h14;
  localparam logic [7:0] OP_DROP_LAST_CHAR = 8'h13;
  localparam logic [7:0] OP_CRC_UPDATE = 8'h04;
  localparam logic [7:0] OP_ZERO_TABLE_ENTRY = 8'h5F;
  localparam logic [7:0] OP_ZERO_INDEXED_ENTRY = 8'h8F;
  localparam logic [7:0] OP_ZERO_R = 8'h9F;
  localparam logic [7:0] OP_ZERO_B = 8'hBF;
  localparam logic [7:0] OP_BCD_ADD_TABLE = 8'h5A;
  localparam logic [7:0] OP_BCD_ADD_IMMEDIATE = 8'h9A;
  localparam logic [7:0] OP_SUBTRACT_ONE = 8'h50;

  // ----------------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [7:0] opcode;
    logic [7:0] operand;
  } instr_t;

  typedef struct packed {
    logic carry;
    logic sign_indicator;
    logic zero;
  } flags_t;

  localparam flags_t FLAGS_RESET = 3'b000;

endpackage

// [verification/chan_ops_unit_sva.sv]
/*
  Port-level checker for the channel arithmetic and clear unit.
  Assumes one clock domain and a bind by port name to chan_ops_unit.
*/
module chan_ops_unit_sva
  import chan_ops_pkg::*;
(
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic resetn,
  // Issue and table side.
  input wire logic issue,
  input wire instr_t instr,
  input wire logic [7:0] table_rd_index,
  input wire logic table_wr,
  input wire logic [7:0] table_wr_index,
  input wire logic [7:0] table_wr_data,
  // Control block side.
  input wire logic block_load,
  input wire logic [15:0] block_init_addr,
  input wire logic [15:0] block_init_range,
  input wire logic store_done,
  // State outputs.
  input wire logic [7:0] r_reg,
  input wire logic [7:0] b_reg,
  input wire flags_t flags,
  input wire logic [15:0] cur_addr,
  input wire logic [15:0] cur_range,
  input wire logic decoded
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  logic [8:0] sum_r;
  logic [8:0] sum_b;
  logic [15:0] init_a;
  logic [15:0] init_r;

  // Nine-bit sums keep the carry out of bit seven for the immediate adds.
  always_ff @(posedge ref_clk) begin
    sum_r <= {1'b0, r_reg} + {1'b0, instr.operand} + {8'h00, flags.carry};
    sum_b <= {1'b0, b_reg} + {1'b0, instr.operand} + {8'h00, flags.carry};
  end

  // Shadow of the initial block values, needed by rewind and drop.
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      init_a <= 16'h0000;
      init_r <= 16'h0000;
    end else if (block_load) begin
      init_a <= block_init_addr;
      init_r <= block_init_range;
    end
  end

  sequence op_taken(logic [7:0] code);
    issue && instr.opcode == code;
  endsequence
  sequence drop_taken;
    op_taken(OP_DROP_LAST_CHAR) ##0 !block_load;
  endsequence

  imm_r_add_a: assert property (op_taken(OP_CARRY_ADD_R_IMMEDIATE) |=>
    {flags.carry, r_reg} == sum_r && flags.sign_indicator == r_reg[7]
    && flags.zero == (r_reg == 8'h00)) else $error("R immediate add wrong");
  imm_b_add_a: assert property (op_taken(OP_CARRY_ADD_B_IMMEDIATE) |=>
    {flags.carry, b_reg} == sum_b) else $error("B immediate add wrong");
  entry_clear_a: assert property (op_taken(OP_ZERO_TABLE_ENTRY) |->
    table_wr && table_wr_index == instr.operand && table_wr_data == 8'h00)
    else $error("table entry clear wrong");
  index_clear_a: assert property (op_taken(OP_ZERO_INDEXED_ENTRY) |->
    table_wr && table_wr_index == b_reg && table_wr_data == 8'h00)
    else $error("indexed entry clear wrong");
  index_read_a: assert property (op_taken(OP_CARRY_ADD_R_INDEXED) |->
    table_rd_index == b_reg) else $error("indexed read uses wrong entry");
  reg_clear_a: assert property (op_taken(OP_ZERO_R) |=>
    r_reg == 8'h00 && $stable(flags)) else $error("R clear wrong");
  crc_keep_a: assert property (op_taken(OP_CRC_UPDATE) |=>
    $stable(flags) && $stable(r_reg)) else $error("block check upset state");
  block_rewind_a: assert property (op_taken(OP_REWIND_BLOCK) ##0 !block_load
    |=> cur_addr == init_a && cur_range == init_r && $stable(flags))
    else $error("block rewind wrong");
  drop_step_a: assert property (drop_taken ##0 cur_range != init_r |=>
    cur_addr == $past(cur_addr) - 16'h0001 && !flags.zero
    && cur_range == $past(cur_range) + 16'h0001) else $error("drop wrong");
  drop_idle_a: assert property (drop_taken ##0 cur_range == init_r
    ##0 !store_done |=>
    $stable(cur_addr) && $stable(cur_range) && flags.zero)
    else $error("drop at start of block not ignored");
  decrement_a: assert property (op_taken(OP_SUBTRACT_ONE) |=>
    r_reg == $past(r_reg) - 8'h01 && flags.carry == ($past(r_reg) == 8'h00))
    else $error("decrement wrong");
endmodule // chan_ops_unit_sva

bind chan_ops_unit chan_ops_unit_sva chk_i (.*);

// [verification/channel_program_arith_clear_ops_bench.sv]
/*
  Self-checking bench for chan_ops_unit; models the table as an array.
  Assumes the package and the checker are compiled first.
*/
module channel_program_arith_clear_ops_bench
  import chan_ops_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic ref_clk = 1'b0;
  logic resetn = 1'b0;
  logic issue = 1'b0;
  logic block_load = 1'b0;
  logic store_done = 1'b0;
  instr_t instr = 16'h0000;
  logic table_wr, decoded;
  logic [7:0] rd_idx, wr_idx, wr_data, r_reg, b_reg;
  logic [15:0] cur_addr, cur_range, crc_residue;
  flags_t flags;
  logic [7:0] tbl [256];
  int miscompares = 0;
  int num_checks = 0;
  int cycles = 0;

  chan_ops_unit dut (.ref_clk(ref_clk), .resetn(resetn), .issue(issue),
    .instr(instr), .table_rd_index(rd_idx), .table_rd_data(tbl[rd_idx]),
    .table_wr(table_wr), .table_wr_index(wr_idx), .table_wr_data(wr_data),
    .block_load(block_load), .block_init_addr(16'h1000),
    .block_init_range(16'h0010), .store_done(store_done), .r_reg(r_reg),
    .b_reg(b_reg), .flags(flags), .cur_addr(cur_addr),
    .cur_range(cur_range), .crc_residue(crc_residue), .decoded(decoded));

  // Clock at 100 ns period.
  initial forever #50 ref_clk = ~ref_clk;

  // Table writes land on the rising edge, as a real memory port would.
  always @(posedge ref_clk) if (table_wr) tbl[wr_idx] <= wr_data;

  // The tests need under 100 cycles, so 400 means a hang.
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 400) begin
      miscompares++;
      test_done();
    end
  end

  task automatic chk(input string name, input logic [15:0] seen, exp);
    num_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // Issue stays high so that operations can follow back to back.
  task automatic op(input logic [7:0] code, input logic [7:0] arg);
    issue = 1'b1;
    instr = {code, arg};
    @(negedge ref_clk);
  endtask

  task automatic stores(input int n);
    issue = 1'b0;
    store_done = 1'b1;
    repeat (n) @(negedge ref_clk);
    store_done = 1'b0;
  endtask

  task automatic t_carry_add_op();
    op(OP_CARRY_ADD_R_IMMEDIATE, 8'hFF);
    chk("flags", flags, 3'b010);
    op(OP_CARRY_ADD_R_IMMEDIATE, 8'h01);
    chk("r", r_reg, 8'h00);
    chk("flags", flags, 3'b101);
    op(OP_ZERO_B, 8'h00);
    chk("flags", flags, 3'b101);
    op(OP_CARRY_ADD_B_IMMEDIATE, 8'h7F);
    chk("b", b_reg, 8'h80);
    op(OP_CARRY_ADD_B_TABLE, 8'h10);
    chk("b", b_reg, 8'hC4);
    op(OP_CARRY_ADD_R_INDEXED, 8'h00);
    chk("r", r_reg, 8'h3B);
    op(OP_CARRY_ADD, 8'h10);
    chk("r", r_reg, 8'h7F);
    $display("test carry_add_op done");
  endtask

  task automatic t_clear();
    op(OP_CARRY_ADD_R_IMMEDIATE, 8'h81);
    op(OP_ZERO_TABLE_ENTRY, 8'h20);
    op(OP_ZERO_INDEXED_ENTRY, 8'h00);
    chk("entry", tbl[8'h20], 8'h00);
    chk("indexed", tbl[8'hC4], 8'h00);
    chk("flags", flags, 3'b101);
    $display("test clear done");
  endtask

  task automatic t_bcd();
    op(OP_ZERO_R, 8'h00);
    op(OP_BCD_ADD_IMMEDIATE, 8'h45);
    op(OP_BCD_ADD_IMMEDIATE, 8'h55);
    chk("flags", {r_reg, 5'h00, flags}, 16'h0005);
    op(OP_BCD_ADD_TABLE, 8'h30);
    chk("r", r_reg, 8'h19);
    op(OP_BCD_ADD_IMMEDIATE, 8'h38);
    chk("r", r_reg, 8'h57);
    op(OP_BCD_ADD_IMMEDIATE, 8'h0A);
    chk("r", r_reg, 8'h67);
    op(OP_ZERO_R, 8'h00);
    op(OP_SUBTRACT_ONE, 8'h00);
    chk("dec", {r_reg, 5'h00, flags}, 16'hFF06);
    op(OP_SUBTRACT_ONE, 8'h00);
    chk("dec", {r_reg, 5'h00, flags}, 16'hFE02);
    $display("test bcd done");
  endtask

  task automatic t_block();
    issue = 1'b0;
    block_load = 1'b1;
    @(negedge ref_clk);
    block_load = 1'b0;
    stores(2);
    op(OP_DROP_LAST_CHAR, 8'h00);
    chk("addr", cur_addr, 16'h1001);
    chk("zero", flags.zero, 1'b0);
    stores(1);
    chk("addr", cur_addr, 16'h1002);
    op(OP_DROP_LAST_CHAR, 8'h00);
    op(OP_DROP_LAST_CHAR, 8'h00);
    op(OP_DROP_LAST_CHAR, 8'h00);
    chk("addr", cur_addr, 16'h1000);
    chk("range", cur_range, 16'h0010);
    chk("flags", flags, 3'b011);
    stores(3);
    op(OP_REWIND_BLOCK, 8'h00);
    chk("addr", cur_addr, 16'h1000);
    chk("range", cur_range, 16'h0010);
    chk("flags", flags, 3'b011);
    $display("test block done");
  endtask

  task automatic t_crc();
    op(OP_ZERO_R, 8'h00);
    op(OP_CARRY_ADD_R_IMMEDIATE, 8'h01);
    op(OP_CRC_UPDATE, 8'h00);
    chk("crc", crc_residue, 16'hC0C1);
    op(8'hFF, 8'h00);
    chk("decoded", decoded, 1'b0);
    issue = 1'b0;
    @(negedge ref_clk);
    chk("r", r_reg, 8'h01);
    $display("test crc done");
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // Main sequence: table contents, reset, then the scenarios.
  initial begin
    foreach (tbl[i]) tbl[i] = 8'h00;
    tbl[8'h10] = 8'h44;
    tbl[8'h20] = 8'h77;
    tbl[8'h30] = 8'h19;
    tbl[8'hC4] = 8'h3B;
    repeat (6) @(negedge ref_clk);
    resetn = 1'b1;
    chk("reset", {r_reg, b_reg}, 16'h0000);
    t_carry_add_op();
    t_clear();
    t_bcd();
    t_block();
    t_crc();
    test_done();
  end
endmodule // channel_program_arith_clear_ops_bench
